// >>> rtl/prr_pattern_mem.sv
/*
 * prr_pattern_mem: four pages of four pattern bytes, one 32-bit word a page.
 * one byte-enabled write port, two read ports with registered data.
 */
`timescale 1ns/1ns
`default_nettype none
module prr_pattern_mem (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // write port
    input wire logic wr_en,
    input wire logic [1:0] wr_page,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_be,
    // read ports
    input wire logic [1:0] rd_a_page,
    output logic [31:0] rd_a_q,
    input wire logic [1:0] rd_b_page,
    output logic [31:0] rd_b_q
);
    logic [31:0] mem_q [4];

    genvar p, b;
    generate
        for (p = 0; p < 4; p++) begin : g_page
            for (b = 0; b < 4; b++) begin : g_byte
                always_ff @(posedge clk_sys or negedge arst_n) begin
                    if (!arst_n) begin
                        mem_q[p][8*b +: 8] <= (p == 0) ? prr_pkg::PAGE0_RST[8*b +: 8]
                                                       : prr_pkg::PAGEX_RST[8*b +: 8];
                    end else if (wr_en && wr_page == 2'(p) && wr_be[b]) begin
                        mem_q[p][8*b +: 8] <= wr_data[8*b +: 8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_a_q <= '0;
            rd_b_q <= '0;
        end else begin
            rd_a_q <= mem_q[rd_a_page];
            rd_b_q <= mem_q[rd_b_page];
        end
    end
endmodule : prr_pattern_mem
`default_nettype wire

// >>> rtl/prr_pkg.sv
/*
 * prr_pkg: shared constants and types of the pattern register readout block.
 * assumes a 10 MHz system clock and a dram command clock sampled by it.
 */
package prr_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LAT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PAGE0 = 8'h10;
    localparam logic [7:0] OFS_PAGE3 = 8'h1C;

    // ctrl fields
    localparam int CTRL_WIDTH_LSB = 0;
    localparam int CTRL_PRE2_BIT = 2;
    localparam int CTRL_PAR_BIT = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;

    // latency fields
    localparam int LAT_CL_LSB = 0;
    localparam int LAT_AL_LSB = 8;
    localparam int LAT_PL_LSB = 16;
    localparam logic [31:0] LAT_RST = 32'h0000_000B;

    // pattern page reset contents {loc3, loc2, loc1, loc0}
    localparam logic [31:0] PAGE0_RST = 32'h000F_3355;
    localparam logic [31:0] PAGEX_RST = 32'h0000_0000;

    // mode register 3 / mode register 0 fields on the address pins
    localparam int MR3_EN_BIT = 2;
    localparam int MR3_FMT_LSB = 11;
    localparam int MR3_PAGE_LSB = 0;
    localparam int MR0_BL_LSB = 0;
    localparam int ADDR_ORDER_BIT = 2;
    localparam int ADDR_CHOP_BIT = 12;
    localparam logic [2:0] MR_SEL_MR0 = 3'h0;
    localparam logic [2:0] MR_SEL_MR3 = 3'h3;

    // readout formats
    localparam logic [1:0] FMT_SERIAL = 2'h0;
    localparam logic [1:0] FMT_PARALLEL = 2'h1;
    localparam logic [1:0] FMT_STAGGER = 2'h2;

    // burst length field of mode register 0
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    // command-clock delay line depth, last beat of a burst
    localparam int LINE_DEPTH = 80;
    localparam logic [2:0] BEAT_LAST = 3'h7;

    // command pins after synchronising
    typedef struct packed {
        logic ck;
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] addr;
    } prr_pins_t;

    // one pending pattern read
    typedef struct packed {
        logic valid;
        logic [1:0] loc;
        logic order;
        logic chop;
    } prr_entry_t;

    typedef enum logic {MODE_NORMAL, MODE_PATTERN} prr_mode_t;

endpackage : prr_pkg

// >>> rtl/prr_readout.sv
/*
 * prr_readout: pattern register readout path of a dram device, with a
 * wishbone slave for pattern contents, latencies and device width.
 * assumes the command clock ck is much slower than clk_sys (8x or more).
 */
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module prr_readout (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // dram command pins
    input wire logic ck,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [17:0] addr,
    // data and strobe pins
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe,
    output logic dqs_t_o,
    output logic dqs_c_o,
    output logic dqs_oe
);
    ////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic cmd_is(input prr_pkg::prr_pins_t p, input logic r,
                                    input logic c, input logic w);
        cmd_is = !p.cs_n && p.act_n && p.ras_n == r && p.cas_n == c && p.we_n == w;
    endfunction : cmd_is

    function automatic logic [7:0] pat_byte(input logic [31:0] pg, input logic [1:0] loc);
        pat_byte = pg[8*loc +: 8];
    endfunction : pat_byte

    function automatic logic lane_bit(input logic [1:0] fmt, input logic [31:0] pg,
                                      input logic [1:0] loc, input logic [2:0] ui,
                                      input logic [3:0] lane);
        logic [7:0] by;
        by = 8'h00;
        lane_bit = 1'b0;
        case (fmt)
            prr_pkg::FMT_SERIAL: begin
                by = pat_byte(pg, loc);
                lane_bit = by[3'h7 - ui];
            end
            prr_pkg::FMT_PARALLEL: begin
                by = pat_byte(pg, 2'h0);
                lane_bit = by[3'h7 - lane[2:0]];
            end
            prr_pkg::FMT_STAGGER: begin
                by = pat_byte(pg, loc + lane[1:0]);
                lane_bit = by[3'h7 - ui];
            end
            default: begin
                lane_bit = 1'b0;
            end
        endcase
    endfunction : lane_bit

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronising and command decode

    prr_pkg::prr_pins_t pins_raw;
    prr_pkg::prr_pins_t pins_s;
    logic ck_prev_q;

    assign pins_raw = '{ck: ck, cs_n: cs_n, act_n: act_n, ras_n: ras_n, cas_n: cas_n,
                        we_n: we_n, bg: bg, ba: ba, addr: addr};

    prr_sync #(.W($bits(prr_pkg::prr_pins_t))) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d(pins_raw),
        .q(pins_s)
    );

    wire ck_rise = pins_s.ck && !ck_prev_q;
    wire ck_fall = !pins_s.ck && ck_prev_q;
    wire [2:0] mr_sel = {pins_s.bg[0], pins_s.ba};
    wire mrs_cmd = ck_rise && cmd_is(pins_s, 1'b0, 1'b0, 1'b0);
    wire rd_cmd = ck_rise && cmd_is(pins_s, 1'b1, 1'b0, 1'b1);
    wire mr3_wr = mrs_cmd && mr_sel == prr_pkg::MR_SEL_MR3;
    wire mr0_wr = mrs_cmd && mr_sel == prr_pkg::MR_SEL_MR0;

    ////////////////////////////////////////////////////////////////////////////
    // mode state

    prr_pkg::prr_mode_t mode_q;
    logic [1:0] fmt_q;
    logic [1:0] page_q;
    logic [1:0] bl_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ck_prev_q <= 1'b0;
            mode_q <= prr_pkg::MODE_NORMAL;
            fmt_q <= prr_pkg::FMT_SERIAL;
            page_q <= 2'h0;
            bl_q <= prr_pkg::BL_FIXED8;
        end else begin
            ck_prev_q <= pins_s.ck;
            if (mr3_wr) begin
                mode_q <= pins_s.addr[prr_pkg::MR3_EN_BIT] ? prr_pkg::MODE_PATTERN
                                                            : prr_pkg::MODE_NORMAL;
                fmt_q <= pins_s.addr[prr_pkg::MR3_FMT_LSB +: 2];
                page_q <= pins_s.addr[prr_pkg::MR3_PAGE_LSB +: 2];
            end
            if (mr0_wr) begin
                bl_q <= pins_s.addr[prr_pkg::MR0_BL_LSB +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read capture and latency delay line

    logic [31:0] ctrl_q;
    logic [31:0] lat_q;
    prr_pkg::prr_entry_t new_e;
    prr_pkg::prr_entry_t line_q [prr_pkg::LINE_DEPTH];

    wire in_mode = mode_q == prr_pkg::MODE_PATTERN;
    wire chop_sel = bl_q == prr_pkg::BL_FIXED4 ||
                    (bl_q == prr_pkg::BL_OTF && !pins_s.addr[prr_pkg::ADDR_CHOP_BIT]);
    wire [6:0] rl_al = {2'h0, lat_q[prr_pkg::LAT_AL_LSB +: 5]};
    wire [6:0] rl_cl = {2'h0, lat_q[prr_pkg::LAT_CL_LSB +: 5]};
    wire [6:0] rl_pl = ctrl_q[prr_pkg::CTRL_PAR_BIT] ? {4'h0, lat_q[prr_pkg::LAT_PL_LSB +: 3]}
                                                      : 7'h00;
    wire [6:0] rl = rl_al + rl_cl + rl_pl;
    wire [6:0] tap_start = rl - 7'h01;
    wire [6:0] tap_pre1 = rl - 7'h02;
    wire [6:0] tap_pre2 = rl - 7'h03;

    // bank address picks the location; address bit 2 sets the order and, with BL_OTF, a low bit 12 chops
    assign new_e = '{valid: rd_cmd && in_mode, loc: pins_s.ba,
                     order: pins_s.addr[prr_pkg::ADDR_ORDER_BIT], chop: chop_sel};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            line_q[0] <= '0;
        end else if (ck_rise) begin
            line_q[0] <= new_e;
        end
    end

    genvar k;
    generate
        for (k = 1; k < prr_pkg::LINE_DEPTH; k++) begin : g_line
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    line_q[k] <= '0;
                end else if (ck_rise) begin
                    line_q[k] <= line_q[k-1];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // burst engine

    prr_pkg::prr_entry_t cur_q;
    logic burst_q;
    logic pre_q;
    logic [2:0] beat_q;

    wire start_now = ck_rise && line_q[tap_start].valid;
    wire pre_now = line_q[tap_pre1].valid ||
                   (ctrl_q[prr_pkg::CTRL_PRE2_BIT] && line_q[tap_pre2].valid);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            burst_q <= 1'b0;
            pre_q <= 1'b0;
            beat_q <= 3'h0;
            cur_q <= '0;
        end else if (ck_rise) begin
            pre_q <= pre_now;
            if (start_now) begin
                burst_q <= 1'b1;
                beat_q <= 3'h0;
                cur_q <= line_q[tap_start];
            end else if (burst_q && beat_q == prr_pkg::BEAT_LAST) begin
                burst_q <= 1'b0;
            end else if (burst_q) begin
                beat_q <= beat_q + 3'h1;
            end
        end else if (ck_fall && burst_q) begin
            beat_q <= beat_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data and strobe outputs

    logic [31:0] pat_q;
    logic [31:0] wb_pat_q;
    logic [15:0] lane_d;
    logic [15:0] lane_used;

    wire [2:0] ui = {beat_q[2] ^ cur_q.order, beat_q[1:0]};
    wire tail_off = cur_q.chop && beat_q[2];
    wire fmt_ok = fmt_q != 2'h3;
    wire [1:0] width = ctrl_q[prr_pkg::CTRL_WIDTH_LSB +: 2];

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_lane
            assign lane_d[i] = lane_bit(fmt_q, pat_q, cur_q.loc, ui, 4'(i));
            assign lane_used[i] = (i < 4) || (i < 8 && width != 2'h0) || width == 2'h2;
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dq_o <= 16'h0000;
            dq_oe <= 16'h0000;
            dqs_t_o <= 1'b0;
            dqs_c_o <= 1'b1;
            dqs_oe <= 1'b0;
        end else begin
            dq_o <= burst_q ? (lane_d & lane_used) : 16'h0000;
            dq_oe <= (burst_q && !tail_off && fmt_ok) ? lane_used : 16'h0000;
            dqs_t_o <= burst_q && !beat_q[0];
            dqs_c_o <= !(burst_q && !beat_q[0]);
            dqs_oe <= (burst_q && !tail_off) || pre_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pattern store

    wire wb_req = wb_cyc_i && wb_stb_i;
    wire pg_hit = wb_adr_i >= prr_pkg::OFS_PAGE0 && wb_adr_i <= prr_pkg::OFS_PAGE3 &&
                  wb_adr_i[1:0] == 2'h0;
    wire [1:0] wb_page = wb_adr_i[3:2];
    logic stage_q;

    prr_pattern_mem u_mem (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .wr_en(wb_ack_o && wb_req && wb_we_i && pg_hit),
        .wr_page(wb_page),
        .wr_data(wb_dat_i),
        .wr_be(wb_sel_i),
        .rd_a_page(page_q),
        .rd_a_q(pat_q),
        .rd_b_page(wb_page),
        .rd_b_q(wb_pat_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave

    logic [31:0] be_mask;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    assign be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign status_w = {24'h0000_00, bl_q, burst_q, page_q, fmt_q, in_mode};
    assign rd_mux = (wb_adr_i == prr_pkg::OFS_CTRL) ? ctrl_q :
                    (wb_adr_i == prr_pkg::OFS_LAT) ? lat_q :
                    (wb_adr_i == prr_pkg::OFS_STATUS) ? status_w :
                    pg_hit ? wb_pat_q : 32'h0000_0000;

    wire wr_go = wb_ack_o && wb_req && wb_we_i;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            stage_q <= wb_req && !wb_ack_o && !stage_q;
            wb_ack_o <= stage_q && wb_req;
            if (stage_q) begin
                wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= prr_pkg::CTRL_RST;
            lat_q <= prr_pkg::LAT_RST;
        end else if (wr_go) begin
            if (wb_adr_i == prr_pkg::OFS_CTRL) begin
                ctrl_q <= (ctrl_q & ~be_mask) | (wb_dat_i & be_mask);
            end
            if (wb_adr_i == prr_pkg::OFS_LAT) begin
                lat_q <= (lat_q & ~be_mask) | (wb_dat_i & be_mask);
            end
        end
    end
endmodule : prr_readout
`default_nettype wire

// >>> rtl/prr_sync.sv
/*
 * prr_sync: two flip-flop synchroniser for a group of pin inputs.
 * assumes each bit is a slow level relative to clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none
module prr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : prr_sync
`default_nettype wire

// >>> test/prr_ctl_model.sv
/* prr_ctl_model: controller side of the command pins, with tasks for mode
   register writes and pattern reads.
   assumes clk_sys at 100 ns; the command clock runs free at 8 clk_sys periods. */
`timescale 1ns/1ns
`default_nettype none
module prr_ctl_model #(
    parameter int MOD_CK = 24,
    parameter int PRE_CK = 4
) (
    // system clock
    input wire logic clk_sys,
    // command pins
    output logic ck,
    output logic cs_n,
    output logic act_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] bg,
    output logic [1:0] ba,
    output logic [17:0] addr
);
    logic [2:0] cnt_q = 3'h0;
    time t_cmd = 0;
    initial begin
        ck = 1'b1;
        {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1f;
        {bg, ba, addr} = 22'h0;
    end
    always @(posedge clk_sys) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h3) ck <= 1'b0;
        if (cnt_q == 3'h7) ck <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_fall;
        do @(posedge clk_sys); while (cnt_q != 3'h3);
    endtask : wait_fall
    // c is {ras_n, cas_n, we_n}; on release cs_n goes high, {bg, ba} and addr take the inverse of {1'b0, sel} and a
    task automatic send(input logic [2:0] c, input logic [2:0] sel, input logic [17:0] a,
                        input int idle);
        wait_fall();
        t_cmd = $time + 400;
        cs_n <= 1'b0;
        act_n <= 1'b1;
        {ras_n, cas_n, we_n} <= c;
        {bg, ba} <= {1'b0, sel};
        addr <= (c == 3'h5) ? {a[17:2], 2'h0} : a;
        wait_fall();
        cs_n <= 1'b1;
        {bg, ba} <= ~{1'b0, sel};
        addr <= ~a;
        repeat (idle) wait_fall();
    endtask : send
    task automatic mrs(input logic [2:0] sel, input logic [17:0] a);
        repeat (PRE_CK) wait_fall();
        send(3'h0, sel, a, MOD_CK);
    endtask : mrs
    task automatic rd(input logic [1:0] loc, input logic [17:0] a, input int gap);
        send(3'h5, {1'b0, loc}, a, gap - 2);
    endtask : rd
endmodule : prr_ctl_model
`default_nettype wire

// >>> test/prr_readout_chk.sv
/* prr_readout_chk: port assertions of the pattern readout block.
   assumes it is bound to prr_readout and sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module prr_readout_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // data and strobe
    input wire logic [15:0] dq_o,
    input wire logic [15:0] dq_oe,
    input wire logic dqs_t_o,
    input wire logic dqs_c_o,
    input wire logic dqs_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_pre;
        (dqs_oe && !dqs_t_o && dq_oe == 16'h0)[*8];
    endsequence
    sequence s_beat0;
        ##[1:9] (dqs_oe && dqs_t_o);
    endsequence
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ack_lat; $rose(wb_cyc_i && wb_stb_i) |-> ##[1:3] wb_ack_o; endproperty
    property p_ack_cause; wb_ack_o |-> (wb_cyc_i && wb_stb_i); endproperty
    property p_write_dat; (wb_ack_o && wb_we_i) |-> wb_dat_o == 32'h0000_0000; endproperty
    property p_strobe_pair; dqs_oe |-> dqs_c_o == !dqs_t_o; endproperty
    property p_dq_strobe; dq_oe != 16'h0 |-> dqs_oe; endproperty
    property p_preamble; $rose(dqs_oe) |-> s_pre ##0 s_beat0; endproperty
    property p_beat_hold;
        (dqs_oe && $past(dqs_oe) && $changed(dqs_t_o)) |=> ($stable(dqs_t_o) && $stable(dq_o))[*3];
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_write_dat: assert property (p_write_dat) else $error("write ack with data");
    a_strobe_pair: assert property (p_strobe_pair) else $error("strobe pair not inverse");
    a_dq_strobe: assert property (p_dq_strobe) else $error("data without strobe");
    a_preamble: assert property (p_preamble) else $error("preamble wrong");
    a_beat_hold: assert property (p_beat_hold) else $error("beat not held half clock");
endmodule : prr_readout_chk
`default_nettype wire

// >>> test/prr_readout_test.sv
/* prr_readout_test: register and pattern read scenarios of prr_readout.
   assumes the controller model prr_ctl_model and the checker prr_readout_chk. */
`timescale 1ns/1ns
`default_nettype none
module prr_readout_test;
    localparam logic [31:0] PG2 = 32'h96C3_A55A;
    localparam int GAP_S = 4;
    localparam int GAP_L = 6;
    logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0] wb_sel_i;
    logic ck, cs_n, act_n, ras_n, cas_n, we_n, dqs_t_o, dqs_c_o, dqs_oe;
    logic [1:0] bg, ba;
    logic [17:0] addr;
    logic [15:0] dq_o, dq_oe;
    int num_errors = 0;
    int checks = 0;
    int quiet = 0;
    prr_readout u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ck(ck), .cs_n(cs_n),
        .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba),
        .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o),
        .dqs_oe(dqs_oe));
    prr_ctl_model u_ctl (.clk_sys(clk_sys), .ck(ck), .cs_n(cs_n), .act_n(act_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int t;
        t = 0;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge clk_sys);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        chk(32'(t < 20), 32'h1);
    endtask : wb
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf, q);
    endtask : wr32
    task automatic rd32(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf, q);
        chk(q, e);
    endtask : rd32
    task automatic mr3(input logic en, input logic [1:0] fmt, input logic [1:0] pg);
        u_ctl.mrs(prr_pkg::MR_SEL_MR3, {5'h0, fmt, 8'h0, en, pg});
    endtask : mr3
    function automatic logic [15:0] mask(input logic [1:0] wid);
        return (wid == 2'h0) ? 16'h000f : (wid == 2'h1) ? 16'h00ff : 16'hffff;
    endfunction : mask
    function automatic logic [15:0] exp_beat(input logic [1:0] fmt, input logic [1:0] wid,
            input logic [31:0] pg, input logic [1:0] loc, input logic [2:0] ui);
        logic [15:0] v;
        logic [1:0] l;
        for (int i = 0; i < 16; i++) begin
            l = (fmt == prr_pkg::FMT_STAGGER) ? loc + i[1:0] : loc;
            v[i] = (fmt == prr_pkg::FMT_PARALLEL) ? pg[7 - i % 8] : pg[8 * l + 7 - ui];
        end
        return v & mask(wid);
    endfunction : exp_beat
    // waits for the first beat, checks latency when rl is nonzero, then n bursts
    task automatic burst(input logic [1:0] fmt, input logic [1:0] wid, input logic [31:0] pg,
            input logic [1:0] loc, input logic ord, input logic chop, input int rl, input int n);
        int t;
        int d;
        logic [15:0] m;
        t = 0;
        while (!(dqs_oe === 1'b1 && dqs_t_o === 1'b1) && t < 400) begin
            @(negedge clk_sys);
            t++;
        end
        d = int'(($time - u_ctl.t_cmd) / 100);
        chk(32'(t < 400), 32'h1);
        if (rl > 0) chk(32'(d >= rl * 8 + 2 && d <= rl * 8 + 5), 32'h1);
        for (int k = 0; k < 8 * n; k++) begin
            @(negedge clk_sys);
            m = (fmt == 2'h3 || (chop && k % 8 > 3)) ? 16'h0 : mask(wid);
            chk(32'(dq_oe), 32'(m));
            if (m != 16'h0) chk(32'(dq_o), 32'(exp_beat(fmt, wid, pg, loc + 2'(k / 8),
                3'(k % 8) ^ {ord, 2'h0})));
            chk(32'(dqs_oe), 32'(!(chop && k % 8 > 3)));
            repeat (3) @(negedge clk_sys);
        end
    endtask : burst
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #3_000_000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = 48'h0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd32(prr_pkg::OFS_CTRL, prr_pkg::CTRL_RST);
        rd32(prr_pkg::OFS_LAT, prr_pkg::LAT_RST);
        rd32(prr_pkg::OFS_PAGE0, prr_pkg::PAGE0_RST);
        rd32(prr_pkg::OFS_PAGE3, prr_pkg::PAGEX_RST);
        wr32(prr_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        rd32(prr_pkg::OFS_STATUS, 32'h0000_0000);
        rd32(8'h40, 32'h0000_0000);
        wb(1'b1, prr_pkg::OFS_CTRL, 32'h0000_00FF, 4'he, q);
        rd32(prr_pkg::OFS_CTRL, prr_pkg::CTRL_RST);
        wr32(8'h18, PG2);
        rd32(8'h18, PG2);
        $display("test registers done");
        mr3(1'b1, prr_pkg::FMT_SERIAL, 2'h2);
        rd32(prr_pkg::OFS_STATUS, 32'h0000_0011);
        u_ctl.rd(2'h1, 18'h0, GAP_L);
        burst(prr_pkg::FMT_SERIAL, 2'h1, PG2, 2'h1, 1'b0, 1'b0, 11, 1);
        u_ctl.rd(2'h3, 18'h0_0004, GAP_L);
        burst(prr_pkg::FMT_SERIAL, 2'h1, PG2, 2'h3, 1'b1, 1'b0, 11, 1);
        u_ctl.mrs(prr_pkg::MR_SEL_MR0, {16'h0, prr_pkg::BL_FIXED4});
        u_ctl.rd(2'h2, 18'h0, GAP_L);
        burst(prr_pkg::FMT_SERIAL, 2'h1, PG2, 2'h2, 1'b0, 1'b1, 11, 1);
        u_ctl.mrs(prr_pkg::MR_SEL_MR0, {16'h0, prr_pkg::BL_OTF});
        u_ctl.rd(2'h0, 18'h0_1000, GAP_L);
        burst(prr_pkg::FMT_SERIAL, 2'h1, PG2, 2'h0, 1'b0, 1'b0, 11, 1);
        u_ctl.mrs(prr_pkg::MR_SEL_MR0, {16'h0, prr_pkg::BL_FIXED8});
        $display("test serial done");
        mr3(1'b1, prr_pkg::FMT_PARALLEL, 2'h0);
        for (int w = 0; w < 3; w += 2) begin
            wr32(prr_pkg::OFS_CTRL, 32'(w));
            u_ctl.rd(2'h0, 18'h0, GAP_S);
            burst(prr_pkg::FMT_PARALLEL, 2'(w), prr_pkg::PAGE0_RST, 2'h0, 1'b0, 1'b0, 11, 1);
        end
        $display("test parallel done");
        mr3(1'b1, prr_pkg::FMT_STAGGER, 2'h0);
        fork
            for (int n = 0; n < 4; n++) u_ctl.rd(2'(n), 18'h0, GAP_S);
            burst(prr_pkg::FMT_STAGGER, 2'h2, prr_pkg::PAGE0_RST, 2'h0, 1'b0, 1'b0, 0, 4);
        join
        wr32(prr_pkg::OFS_LAT, 32'h0002_0109);
        wr32(prr_pkg::OFS_CTRL, 32'h0000_000E);
        u_ctl.rd(2'h2, 18'h0, GAP_S);
        burst(prr_pkg::FMT_STAGGER, 2'h2, prr_pkg::PAGE0_RST, 2'h2, 1'b0, 1'b0, 12, 1);
        $display("test staggered done");
        mr3(1'b1, 2'h3, 2'h0);
        u_ctl.rd(2'h0, 18'h0, GAP_S);
        burst(2'h3, 2'h2, prr_pkg::PAGE0_RST, 2'h0, 1'b0, 1'b0, 12, 1);
        mr3(1'b0, 2'h0, 2'h0);
        u_ctl.rd(2'h0, 18'h0, GAP_S);
        repeat (160) begin
            @(negedge clk_sys);
            if (dqs_oe !== 1'b0 || dq_oe !== 16'h0) quiet++;
        end
        chk(32'(quiet), 32'h0);
        $display("test exit done");
        report_and_stop();
    end
endmodule : prr_readout_test
bind prr_readout prr_readout_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_t_o(dqs_t_o),
    .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe));
`default_nettype wire
